// ==== touch_mode_consts.vh ====
/*
 touch_mode_consts.vh: register offsets, reset values, field positions,
 mode codes and tick timing for the touch mode and power controller.
 assumes: included by bare name into design files; definitions only.
*/
`ifndef TOUCH_MODE_CONSTS_VH
`define TOUCH_MODE_CONSTS_VH

`define CLK_MHZ            250
`define MS_CYCLES          (`CLK_MHZ * 1000)
`define FIXED_TICK_MS      8
`define TICK_BASE_MS       5
`define TICK_MIN_MS        5
`define TICK_MAX_MS        31
`define TICK_FORCED        8'h1a

`define OFS_EVENT_QUEUE    4'h0
`define OFS_ERROR_FLAGS    4'h1
`define OFS_ROTARY_NOW     4'h2
`define OFS_ROTARY_SETUP   4'h3
`define OFS_THRESHOLD      4'h4
`define OFS_TICK_LENGTH    4'h5
`define OFS_SCAN_INTERVAL  4'h6
`define OFS_CLICK_TONE     4'h7
`define OFS_SLEEP_POLICY   4'h8
`define OFS_HELD_TIMEOUT   4'h9
`define OFS_MODE_CONTROL   4'ha
`define OFS_PART_REVISION  4'hb

`define RST_EVENT_QUEUE    8'h40
`define RST_ERROR_FLAGS    8'h00
`define RST_ROTARY_NOW     8'h00
`define RST_ROTARY_SETUP   8'h81
`define RST_THRESHOLD      8'h00
`define RST_TICK_LENGTH    8'h05
`define RST_SCAN_INTERVAL  8'h01
`define RST_CLICK_TONE     8'h01
`define RST_SLEEP_POLICY   8'h00
`define RST_HELD_TIMEOUT   8'h00
`define RST_MODE_CONTROL   8'h14

`define BIT_RUN_ENABLE     0
`define BIT_IRQ_ENABLE     1
`define BIT_DUTY_DISABLE   2
`define BIT_SOFT_RESET_N   4
`define SPACING_HI         7
`define SPACING_LO         5

`define MODE_DEEP_OFF      2'b00
`define MODE_DUTY_RUN      2'b01
`define MODE_IDLE_LISTEN   2'b10
`define MODE_FULL_RUN      2'b11

`endif

// ==== tick_timebase.v ====
/*
 tick_timebase.v: master tick divider; one-cycle pulse per tick period.
 assumes: clk at 250 MHz; period_ms given in whole milliseconds.
*/
`timescale 1ns/100ps
`include "touch_mode_consts.vh"

module tick_timebase #(
    parameter [31:0] MS_CYCLES = `MS_CYCLES
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       run,
    input  wire [5:0] period_ms,
    output reg        tick
);
    reg [17:0] ms_cnt_r;
    reg [5:0]  ms_left_r;
    wire       ms_end = (ms_cnt_r == MS_CYCLES[17:0] - 18'h00001);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_cnt_r  <= 18'h00000;
            ms_left_r <= 6'h00;
            tick      <= 1'b0;
        end else if (!run) begin
            ms_cnt_r  <= 18'h00000;
            ms_left_r <= 6'h00;
            tick      <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (ms_end) begin
                ms_cnt_r <= 18'h00000;
                // period change takes effect at next tick boundary
                if (ms_left_r <= 6'h01) begin
                    ms_left_r <= period_ms;
                    tick      <= 1'b1;
                end else begin
                    ms_left_r <= ms_left_r - 6'h01;
                end
            end else begin
                ms_cnt_r <= ms_cnt_r + 18'h00001;
            end
        end
    end
endmodule // tick_timebase

// ==== touch_mode_power_control.v ====
/*
 touch_mode_power_control.v: mode selection, register map, soft reset,
 master tick and interrupt spacing for the rotary touch controller.
 assumes: a register access port already decoded from the serial link,
 one-cycle wr_en / rd_en strobes, all inputs synchronous to clk.
*/
`timescale 1ns/100ps
`include "touch_mode_consts.vh"

module touch_mode_power_control #(
    parameter [7:0]  PART_REVISION = 8'h5a,  // arbitrary value
    parameter [31:0] MS_CYCLES     = `MS_CYCLES
) (
    input  wire       clk,
    input  wire       rst,
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       wr_en,
    input  wire       rd_en,
    input  wire       attention_wake_pin,
    input  wire       touch_event,
    output reg  [7:0] reg_rdata,
    output reg        rd_valid,
    output reg        interrupt_request_pin,
    output reg        scan_active,
    output reg        master_tick,
    output reg  [1:0] mode
);
    reg [7:0] event_queue_r;
    reg [7:0] error_flags_r;
    reg [7:0] rotary_now_r;
    reg [7:0] rotary_setup_r;
    reg [7:0] threshold_r;
    reg [7:0] tick_length_r;
    reg [7:0] scan_interval_r;
    reg [7:0] click_tone_r;
    reg [7:0] sleep_policy_r;
    reg [7:0] held_timeout_r;
    reg [7:0] mode_ctrl_r;
    reg       attention_wake_pin_prev_r;
    reg [3:0] space_cnt_r;
    reg       irq_pending_r;
    reg       soft_rst_r;
    wire      tick_pulse;

    // tick setting plus base of 5 ms gives the period
    function [8:0] tick_ms;
        input [7:0] setting;
        begin
            tick_ms = {1'b0, setting} + 9'd`TICK_BASE_MS;
        end
    endfunction

    function in_range;
        input [7:0] setting;
        reg   [8:0] ms;
        begin
            ms = tick_ms(setting);
            in_range = (ms >= 9'd`TICK_MIN_MS) && (ms <= 9'd`TICK_MAX_MS);
        end
    endfunction

    // out-of-range settings collapse to the forced code
    function [7:0] tick_fix;
        input [7:0] setting;
        begin
            tick_fix = in_range(setting) ? setting : `TICK_FORCED;
        end
    endfunction

    // one write strike per offset
    function wr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        input       ok;
        begin
            wr_hit = ok & (addr == ofs);
        end
    endfunction

    // spacing code n loads n+1 ticks
    function [3:0] space_load;
        input [2:0] code;
        begin
            space_load = {1'b0, code} + 4'h1;
        end
    endfunction

    // mode code is {duty_cycle_disable, scan_run_enable}
    wire [1:0] mode_now = {mode_ctrl_r[`BIT_DUTY_DISABLE],
                           mode_ctrl_r[`BIT_RUN_ENABLE]};
    wire run_mode  = mode_ctrl_r[`BIT_RUN_ENABLE];
    wire bus_alive = (mode_now == `MODE_FULL_RUN) ||
                     (mode_now == `MODE_IDLE_LISTEN);
    wire attention_wake_pin_fall = attention_wake_pin_prev_r & ~attention_wake_pin;
    wire wr_ok     = wr_en & bus_alive;
    wire wr_mode   = wr_ok & (reg_addr == `OFS_MODE_CONTROL);
    // run modes drop every write; only full run still takes mode control, duty run takes none
    wire wr_other  = wr_ok & ~run_mode;
    // stored settings never exceed 26, so 6 bits hold the period
    wire [8:0] tick_full  = tick_ms(tick_length_r);
    wire [5:0] period_sel = (mode_now == `MODE_FULL_RUN) ?
                            tick_full[5:0]
                            : 6'd`FIXED_TICK_MS;
    wire int_rst = rst | soft_rst_r;

    tick_timebase #(
        .MS_CYCLES (MS_CYCLES)
    ) u_tick (
        .clk       (clk),
        .rst       (int_rst),
        .run       (run_mode),
        .period_ms (period_sel),
        .tick      (tick_pulse)
    );

    // soft reset: one-cycle pulse, restarts all state below
    always @(posedge clk or posedge rst) begin
        if (rst)
            soft_rst_r <= 1'b0;
        else
            soft_rst_r <= wr_mode & ~reg_wdata[`BIT_SOFT_RESET_N];
    end

    // write strikes: one per offset, never in a run mode
    wire sel_queue    = wr_hit(reg_addr, `OFS_EVENT_QUEUE, wr_other);
    wire sel_rotary   = wr_hit(reg_addr, `OFS_ROTARY_SETUP, wr_other);
    wire sel_thresh   = wr_hit(reg_addr, `OFS_THRESHOLD, wr_other);
    wire sel_tick     = wr_hit(reg_addr, `OFS_TICK_LENGTH, wr_other);
    wire sel_interval = wr_hit(reg_addr, `OFS_SCAN_INTERVAL, wr_other);
    wire sel_tone     = wr_hit(reg_addr, `OFS_CLICK_TONE, wr_other);
    wire sel_sleep    = wr_hit(reg_addr, `OFS_SLEEP_POLICY, wr_other);
    wire sel_held     = wr_hit(reg_addr, `OFS_HELD_TIMEOUT, wr_other);

    // edge detector idles high like the pin, so no false edge
    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            attention_wake_pin_prev_r <= 1'b1;
        else
            attention_wake_pin_prev_r <= attention_wake_pin;
    end

    always @(posedge clk or posedge int_rst) begin
        if (int_rst) begin
            mode_ctrl_r <= `RST_MODE_CONTROL;
        end else if (wr_mode) begin
            // soft reset bit reads back as one after the reset
            mode_ctrl_r <= reg_wdata | (8'h01 << `BIT_SOFT_RESET_N);
            if (attention_wake_pin_fall)
                mode_ctrl_r[`BIT_DUTY_DISABLE] <= 1'b1;
        end else if (attention_wake_pin_fall) begin
            // only way out of duty_cycled_run and deep_off
            mode_ctrl_r[`BIT_DUTY_DISABLE] <= 1'b1;
        end
    end

    // status registers: no writer in this block, reset value only
    always @(posedge clk or posedge int_rst) begin
        if (int_rst) begin
            error_flags_r <= `RST_ERROR_FLAGS;
            rotary_now_r  <= `RST_ROTARY_NOW;
        end else begin
            error_flags_r <= error_flags_r;
            rotary_now_r  <= rotary_now_r;
        end
    end

    // a write to the queue empties it, whatever the data
    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            event_queue_r <= `RST_EVENT_QUEUE;
        else if (sel_queue)
            event_queue_r <= `RST_EVENT_QUEUE;
    end

    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            rotary_setup_r <= `RST_ROTARY_SETUP;
        else if (sel_rotary)
            rotary_setup_r <= reg_wdata;
    end

    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            threshold_r <= `RST_THRESHOLD;
        else if (sel_thresh)
            threshold_r <= reg_wdata;
    end

    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            tick_length_r <= `RST_TICK_LENGTH;
        else if (sel_tick)
            tick_length_r <= tick_fix(reg_wdata);
    end

    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            scan_interval_r <= `RST_SCAN_INTERVAL;
        else if (sel_interval)
            scan_interval_r <= reg_wdata;
    end

    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            click_tone_r <= `RST_CLICK_TONE;
        else if (sel_tone)
            click_tone_r <= reg_wdata;
    end

    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            sleep_policy_r <= `RST_SLEEP_POLICY;
        else if (sel_sleep)
            sleep_policy_r <= reg_wdata;
    end

    always @(posedge clk or posedge int_rst) begin
        if (int_rst)
            held_timeout_r <= `RST_HELD_TIMEOUT;
        else if (sel_held)
            held_timeout_r <= reg_wdata;
    end

    // read port: dead in duty_cycled_run and deep_off
    always @(posedge clk or posedge int_rst) begin
        if (int_rst) begin
            reg_rdata <= 8'h00;
            rd_valid  <= 1'b0;
        end else begin
            rd_valid  <= rd_en & bus_alive;
            reg_rdata <= 8'h00;
            if (rd_en & bus_alive) begin
                case (reg_addr)
                    `OFS_EVENT_QUEUE:   reg_rdata <= event_queue_r;
                    `OFS_ERROR_FLAGS:   reg_rdata <= error_flags_r;
                    `OFS_ROTARY_NOW:    reg_rdata <= rotary_now_r;
                    `OFS_ROTARY_SETUP:  reg_rdata <= rotary_setup_r;
                    `OFS_THRESHOLD:     reg_rdata <= threshold_r;
                    `OFS_TICK_LENGTH:   reg_rdata <= tick_length_r;
                    `OFS_SCAN_INTERVAL: reg_rdata <= scan_interval_r;
                    `OFS_CLICK_TONE:    reg_rdata <= click_tone_r;
                    `OFS_SLEEP_POLICY:  reg_rdata <= sleep_policy_r;
                    `OFS_HELD_TIMEOUT:  reg_rdata <= held_timeout_r;
                    `OFS_MODE_CONTROL:  reg_rdata <= mode_ctrl_r;
                    `OFS_PART_REVISION: reg_rdata <= PART_REVISION;
                    default:            reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // interrupt spacing: after each irq, the next pending event waits out n+1 ticks
    always @(posedge clk or posedge int_rst) begin
        if (int_rst) begin
            space_cnt_r           <= 4'h0;
            irq_pending_r         <= 1'b0;
            interrupt_request_pin <= 1'b1;
            scan_active           <= 1'b0;
            master_tick           <= 1'b0;
            mode                  <= `MODE_IDLE_LISTEN;
        end else begin
            scan_active <= run_mode;
            master_tick <= tick_pulse;
            mode        <= mode_now;
            // event beats the clear on the same cycle
            if (touch_event)
                irq_pending_r <= 1'b1;
            else if (!interrupt_request_pin)
                irq_pending_r <= 1'b0;
            interrupt_request_pin <= 1'b1;
            if (space_cnt_r != 4'h0) begin
                if (tick_pulse)
                    space_cnt_r <= space_cnt_r - 4'h1;
            end else if (irq_pending_r &
                         mode_ctrl_r[`BIT_IRQ_ENABLE]) begin
                interrupt_request_pin <= 1'b0;
                space_cnt_r <= space_load(
                    mode_ctrl_r[`SPACING_HI:`SPACING_LO]);
            end
        end
    end
endmodule // touch_mode_power_control

// ==== touch_chk_assertions.sv ====
/*
 touch_chk_assertions.sv: port assertions for the touch mode controller.
 assumes: bound to touch_mode_power_control, clk and rst as at its ports.
*/
`timescale 1ns/100ps
`include "touch_mode_consts.vh"
module touch_chk (
    input wire       clk,
    input wire       rst,
    input wire       rd_en,
    input wire       attention_wake_pin,
    input wire       rd_valid,
    input wire       interrupt_request_pin,
    input wire       scan_active,
    input wire       master_tick,
    input wire [1:0] mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_fall;
        $fell(attention_wake_pin);
    endsequence
    // two quiet pin samples: no wake can be in flight
    sequence s_quiet;
        (!mode[1] && attention_wake_pin) ##1 (!mode[1] && attention_wake_pin);
    endsequence
    // mode output lags the bus gate by one cycle: need it steady
    property p_rd_ans;
        rd_en && mode[1] ##1 mode[1] |-> rd_valid;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read unanswered");
    property p_rd_ref;
        rd_en && !mode[1] ##1 !mode[1] |-> !rd_valid;
    endproperty
    a_rd_ref: assert property (p_rd_ref)
        else $error("read answered");
    property p_irq_rst;
        disable iff (1'b0) rst |-> interrupt_request_pin;
    endproperty
    a_irq_rst: assert property (p_irq_rst)
        else $error("irq low in reset");
    property p_irq_one;
        $fell(interrupt_request_pin) |=> interrupt_request_pin;
    endproperty
    a_irq_one: assert property (p_irq_one)
        else $error("irq pulse long");
    property p_scan;
        (mode == `MODE_FULL_RUN) ##1 (mode == `MODE_FULL_RUN) |-> scan_active;
    endproperty
    a_scan: assert property (p_scan)
        else $error("scan off in run");
    property p_wake;
        s_fall |-> ##[1:3] mode[1];
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake not taken");
    property p_stay;
        s_quiet |=> mode == $past(mode);
    endproperty
    a_stay: assert property (p_stay)
        else $error("left low power mode");
    property p_tick_one;
        master_tick |=> !master_tick;
    endproperty
    a_tick_one: assert property (p_tick_one)
        else $error("tick long");
    property p_idle_tick;
        (mode == `MODE_IDLE_LISTEN) [*3] |-> !master_tick;
    endproperty
    a_idle_tick: assert property (p_idle_tick)
        else $error("tick in idle");
endmodule // touch_chk

bind touch_mode_power_control touch_chk u_chk (.clk, .rst, .rd_en,
    .attention_wake_pin, .rd_valid, .interrupt_request_pin, .scan_active,
    .master_tick, .mode);

// ==== touch_host.sv ====
/*
 touch_host.sv: host model driving the register port and the wake pin.
 assumes: rd_valid answers one cycle after rd_en; inputs change at negedge.
*/
`timescale 1ns/100ps
module touch_host (
    input  wire       clk,
    input  wire       rd_valid,
    input  wire [7:0] reg_rdata,
    output reg  [3:0] reg_addr,
    output reg  [7:0] reg_wdata,
    output reg        wr_en,
    output reg        rd_en,
    output reg        attention_wake_pin
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        attention_wake_pin = 1'b1;
    end
    // released lines scrambled so stale data cannot pass
    task wr(input [3:0] a, input [7:0] dat);
        begin
            @(negedge clk);
            reg_addr = a;
            reg_wdata = dat;
            wr_en = 1'b1;
            @(negedge clk);
            wr_en = 1'b0;
            reg_wdata = ~dat;
        end
    endtask
    task rd(input [3:0] a, output [7:0] dat, output vld);
        begin
            @(negedge clk);
            reg_addr = a;
            rd_en = 1'b1;
            @(negedge clk);
            rd_en = 1'b0;
            vld = rd_valid;
            dat = reg_rdata;
            reg_addr = ~a;
        end
    endtask
    task wake;
        begin
            @(negedge clk);
            attention_wake_pin = 1'b0;
            repeat (4) @(negedge clk);
            attention_wake_pin = 1'b1;
        end
    endtask
endmodule // touch_host

// ==== touch_mode_power_control_tb_top.sv ====
/*
 touch_mode_power_control_tb_top.sv: directed tests of modes, registers,
 tick timing and interrupts. assumes: MS_CYCLES shrunk to 10 per ms.
*/
`timescale 1ns/100ps
`include "touch_mode_consts.vh"
module touch_mode_power_control_tb_top;
    localparam [7:0]   REV = 8'h5a; // arbitrary value
    localparam [103:0] RV = {8'h00, REV, 8'h14, 8'h00, 8'h00, 8'h01, 8'h01,
                             8'h05, 8'h00, 8'h81, 8'h00, 8'h00, 8'h40};
    reg        clk;
    reg        rst;
    reg        touch_event;
    wire [3:0] reg_addr;
    wire [7:0] reg_wdata;
    wire       wr_en;
    wire       rd_en;
    wire       attention_wake_pin;
    wire [7:0] reg_rdata;
    wire       rd_valid;
    wire       interrupt_request_pin;
    wire       scan_active;
    wire       master_tick;
    wire [1:0] mode;
    reg  [7:0] d;
    reg        v;
    integer    n_mismatch;
    integer    n_checks;
    integer    i;
    integer    t;
    touch_mode_power_control #(.PART_REVISION(REV), .MS_CYCLES(10)) dut (
        .clk, .rst, .reg_addr, .reg_wdata, .wr_en, .rd_en,
        .attention_wake_pin, .touch_event, .reg_rdata, .rd_valid,
        .interrupt_request_pin, .scan_active, .master_tick, .mode);
    touch_host host (.clk, .rd_valid, .reg_rdata, .reg_addr, .reg_wdata,
        .wr_en, .rd_en, .attention_wake_pin);
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rdc(input [3:0] a, input [7:0] e);
        begin
            host.rd(a, d, v);
            chk({7'h00, v}, 8'h01);
            chk(d, e);
        end
    endtask
    // mode output lags the write by up to two cycles
    task mchk(input [1:0] e);
        begin
            repeat (3) @(negedge clk);
            chk({6'h00, mode}, {6'h00, e});
        end
    endtask
    // w=0: cycles to next tick, w=1: cycles to next irq low
    task cnt_to(input integer w);
        begin
            @(negedge clk);
            t = 1;
            while (t < 999 && (w ? interrupt_request_pin : !master_tick)
                   !== 0) begin
                @(negedge clk);
                t = t + 1;
            end
        end
    endtask
    task pulse;
        begin
            @(negedge clk);
            touch_event = 1'b1;
            @(negedge clk);
            touch_event = 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #60000;
        n_mismatch = n_mismatch + 1;
        report_and_stop;
    end
    initial begin
        rst = 1'b1;
        touch_event = 1'b0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk({7'h00, interrupt_request_pin}, 8'h01);
        mchk(`MODE_IDLE_LISTEN);
        for (i = 0; i < 13; i = i + 1) begin
            rdc(i[3:0], RV[i*8 +: 8]);
        end
        $display("test reset values done");
        host.wr(`OFS_THRESHOLD, 8'h33);
        host.wr(`OFS_ERROR_FLAGS, 8'h77);
        rdc(`OFS_THRESHOLD, 8'h33);
        rdc(`OFS_ERROR_FLAGS, 8'h00);
        host.wr(`OFS_TICK_LENGTH, 8'd27);
        rdc(`OFS_TICK_LENGTH, `TICK_FORCED);
        host.wr(`OFS_TICK_LENGTH, 8'd26);
        rdc(`OFS_TICK_LENGTH, 8'd26);
        host.wr(`OFS_TICK_LENGTH, 8'h00);
        rdc(`OFS_TICK_LENGTH, 8'h00);
        pulse;
        cnt_to(1);
        chk({7'h00, t == 999}, 8'h01);
        $display("test idle registers done");
        // held event fires on enable, then the next one is spaced
        host.wr(`OFS_MODE_CONTROL, 8'h37);
        cnt_to(1);
        chk({7'h00, t < 8}, 8'h01);
        pulse;
        cnt_to(1);
        chk({7'h00, t > 50 && t < 110}, 8'h01);
        mchk(`MODE_FULL_RUN);
        chk({7'h00, scan_active}, 8'h01);
        rdc(`OFS_MODE_CONTROL, 8'h37);
        host.wr(`OFS_THRESHOLD, 8'h44);
        rdc(`OFS_THRESHOLD, 8'h33);
        cnt_to(0);
        cnt_to(0);
        chk(t[7:0], 8'd50);
        $display("test full run done");
        host.wr(`OFS_MODE_CONTROL, 8'h33);
        mchk(`MODE_DUTY_RUN);
        host.rd(`OFS_THRESHOLD, d, v);
        chk({7'h00, v}, 8'h00);
        cnt_to(0);
        cnt_to(0);
        chk(t[7:0], 8'd80);
        host.wake;
        mchk(`MODE_FULL_RUN);
        rdc(`OFS_MODE_CONTROL, 8'h37);
        $display("test duty run done");
        host.wr(`OFS_MODE_CONTROL, 8'h16);
        mchk(`MODE_IDLE_LISTEN);
        chk({7'h00, scan_active}, 8'h00);
        host.wr(`OFS_MODE_CONTROL, 8'h10);
        mchk(`MODE_DEEP_OFF);
        host.wr(`OFS_MODE_CONTROL, 8'h16);
        mchk(`MODE_DEEP_OFF);
        host.rd(`OFS_MODE_CONTROL, d, v);
        chk({7'h00, v}, 8'h00);
        host.wake;
        mchk(`MODE_IDLE_LISTEN);
        $display("test deep off done");
        host.wr(`OFS_MODE_CONTROL, 8'h06);
        mchk(`MODE_IDLE_LISTEN);
        rdc(`OFS_THRESHOLD, 8'h00);
        rdc(`OFS_MODE_CONTROL, 8'h14);
        $display("test soft reset done");
        report_and_stop;
    end
endmodule // touch_mode_power_control_tb_top
